/* File: hw/ahd_pkg.sv */
// Constants, states and register map of the axis homing and drive block.
// Behaviour
// - Two-bit code picks one of four PWM chopper frequencies, rising with code.
// - Autoscale clear: user amplitude only; set: automatic current-led scaling.
// - Search mode 1 looks for the left stop switch only.
// - Modes 2 and 3 find right then left; mode 3 meets left from both sides.
// - Mode 4 finds the left stop switch approaching from both sides.
// - Mode 5 seeks home going negative, reversing at left; mode 6 mirrored.
// - Mode 7 seeks home positive, mode 8 negative, ignoring end switches.
// - Adding 128 to the mode inverts the home switch polarity.
// - Adding 64 to a stop-switch mode targets the right switch instead.
// - Coarse approach runs at a programmable 24-bit pulse-per-second speed.
// - After modes 2 or 3 the measured switch span reads as signed microsteps.
// - Position is captured into a read-only register just before zeroing.
// - Boost current drives ramps; zero means ramps use the run current.
// - Full steps per revolution is a 16-bit value defaulting to 200.
// - With zero standby current, option picks normal, freewheel, low or high.
// - A read-only 10-bit load measurement is provided for stall detection.
// - Error flags: value 1 marks stall, value 2 marks position deviation.
// - Error flags clear on a read of the error flag register or on any motion command.
package ahd_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam logic [7:0] IDX_PWM_FREQ   = 8'h00BF;
  localparam logic [7:0] IDX_AUTOSCALE  = 8'h00C0;
  localparam logic [7:0] IDX_MODE       = 8'h00C1;
  localparam logic [7:0] IDX_COARSE     = 8'h00C2;
  localparam logic [7:0] IDX_FINE       = 8'h00C3;
  localparam logic [7:0] IDX_SPAN       = 8'h00C4;
  localparam logic [7:0] IDX_PREZERO    = 8'h00C5;
  localparam logic [7:0] IDX_BOOST      = 8'h00C8;
  localparam logic [7:0] IDX_FULLSTEPS  = 8'h00CA;
  localparam logic [7:0] IDX_STANDSTILL = 8'h00CC;
  localparam logic [7:0] IDX_LOAD       = 8'h00CE;
  localparam logic [7:0] IDX_FAULTS     = 8'h00CF;
  localparam logic [7:0] IDX_CONTROL    = 8'h00D0;
  localparam logic [7:0] IDX_STATUS     = 8'h00D1;
  localparam logic [7:0] IDX_POSITION   = 8'h00D2;
  localparam logic [15:0] FULLSTEPS_RST = 16'h00C8;
  localparam logic [7:0]  MODE_RST      = 8'h0001;
  localparam logic [23:0] COARSE_RST    = 24'h00_1000;
  localparam logic [23:0] FINE_RST      = 24'h00_0100;
  localparam logic [7:0]  RUN_CUR_RST   = 8'h0080;
  localparam logic [7:0]  STBY_CUR_RST  = 8'h0040;
  localparam int CTL_START  = 0;
  localparam int CTL_STOP   = 1;
  localparam int CTL_RUN_LO = 8;
  localparam int CTL_STB_LO = 16;
  localparam int MODE_INV_HOME = 7;
  localparam int MODE_RIGHT    = 6;
  localparam int FLT_STALL = 0;
  localparam int FLT_DEV   = 1;
  localparam longint unsigned F0_MHZ = 15_625_000;
  localparam longint unsigned F1_MHZ = 23_426_000;
  localparam longint unsigned F2_MHZ = 31_250_000;
  localparam longint unsigned F3_MHZ = 39_024_000;
  localparam longint unsigned CLK_MHZ = longint'(CLK_HZ) * 1000;
  localparam logic [13:0] PWM_P0 = 14'(CLK_MHZ / F0_MHZ);
  localparam logic [13:0] PWM_P1 = 14'(CLK_MHZ / F1_MHZ);
  localparam logic [13:0] PWM_P2 = 14'(CLK_MHZ / F2_MHZ);
  localparam logic [13:0] PWM_P3 = 14'(CLK_MHZ / F3_MHZ);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FIRST = 3'b001,
    S_SEEK  = 3'b010,
    S_LEAVE = 3'b011,
    S_FINE  = 3'b100,
    S_OVER  = 3'b101,
    S_BACK  = 3'b110
  } ahd_state_t;
endpackage : ahd_pkg

/* File: hw/ahd_step_if.sv */
// Link between the search sequencer and the step rate generator.
`timescale 1ns/1ps
interface ahd_step_if;
  logic        run;
  logic [23:0] speed;
  logic        step;
  modport gen (input run, input speed, output step);
  modport ctl (output run, output speed, input step);
endinterface : ahd_step_if

/* File: hw/ahd_step_gen.sv */
// Step pulse generator turning a pulse-per-second speed into step strobes.
`timescale 1ns/1ps
module ahd_step_gen (
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  ahd_step_if.gen    st
);
  localparam logic [31:0] LIMIT = 32'(ahd_pkg::CLK_HZ);
  logic [31:0] acc_reg;
  logic        step_reg;
  wire  [31:0] acc_sum  = acc_reg + {8'h00, st.speed};
  wire         wrap     = acc_sum >= LIMIT;
  wire  [31:0] acc_next = wrap ? acc_sum - LIMIT : acc_sum;

  // Phase accumulator yields exactly speed pulses per second.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !st.run) begin
      acc_reg  <= 32'h0000_0000;
      step_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      step_reg <= wrap;
    end
  end

  assign st.step = step_reg;
endmodule : ahd_step_gen

/* File: hw/ahd_axis.sv */
// Axis homing search, drive parameters and Avalon-MM register slave.
`timescale 1ns/1ps
module ahd_axis (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_left_sw,
  input  wire logic        i_right_sw,
  input  wire logic        i_home_sw,
  input  wire logic [9:0]  i_load_value,
  input  wire logic        i_stall_evt,
  input  wire logic        i_deviation_evt,
  input  wire logic        i_ramp_active,
  output logic             o_step,
  output logic             o_dir,
  output logic             o_pwm_sync,
  output logic             o_pwm_autoscale,
  output logic [7:0]       o_coil_current,
  output logic [1:0]       o_coil_mode
);
  logic [1:0]  pwm_freq_reg;
  logic        autoscale_reg;
  logic [7:0]  mode_reg;
  logic [23:0] coarse_reg;
  logic [23:0] fine_reg;
  logic [31:0] span_reg;
  logic [31:0] prezero_reg;
  logic [7:0]  boost_reg;
  logic [15:0] fullsteps_reg;
  logic [1:0]  standstill_reg;
  logic [1:0]  fault_reg;
  logic [7:0]  run_cur_reg;
  logic [7:0]  stby_cur_reg;
  logic [31:0] pos_reg;
  logic [31:0] first_pos_reg;
  logic        done_reg;
  logic        dir_reg;
  logic        step_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [13:0] pwm_cnt_reg;
  logic        pwm_sync_reg;
  logic        auto_out_reg;
  logic [7:0]  cur_out_reg;
  logic [1:0]  cmode_out_reg;
  ahd_pkg::ahd_state_t state_reg;
  ahd_pkg::ahd_state_t state_next;

  // Two-stage synchronisers for the switch, event and load pins; i_ramp_active is used unsynchronised.
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire  [NSYNC-1:0] pins = {i_load_value, i_deviation_evt, i_stall_evt,
                            i_home_sw, i_right_sw, i_left_sw};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  logic [1:0] evt_prev_reg;
  wire        left_sw  = sync2_reg[0];
  wire        right_sw = sync2_reg[1];
  wire        home_sw  = sync2_reg[2] ^ mode_reg[ahd_pkg::MODE_INV_HOME];
  wire  [1:0] evt_lvl  = sync2_reg[4:3];
  wire  [1:0] evt_rise = evt_lvl & ~evt_prev_reg;
  wire  [9:0] load_now = sync2_reg[14:5];

  // Bus decode; the address is the byte address, four times the index.
  wire       bus_req  = i_avs_read | i_avs_write;
  wire       bus_done = bus_req & ~wait_reg;
  wire       aligned  = i_avs_address[1:0] == 2'b00;
  wire [7:0] idx      = i_avs_address[9:2];
  wire       wr_en    = i_avs_write & bus_done & aligned;
  wire       rd_fault = i_avs_read & bus_done & aligned &
                        (idx == ahd_pkg::IDX_FAULTS);
  wire       wr_ctl   = wr_en & (idx == ahd_pkg::IDX_CONTROL);
  wire       cmd_start = wr_ctl & i_avs_writedata[ahd_pkg::CTL_START];
  wire       cmd_stop  = wr_ctl & i_avs_writedata[ahd_pkg::CTL_STOP];
  wire       motion_cmd = cmd_start | cmd_stop;

  // Mode decoding for the search sequencer.
  wire [3:0] base      = mode_reg[3:0];
  wire       home_mode = (base >= 4'd5) && (base <= 4'd8);
  wire       use_right = mode_reg[ahd_pkg::MODE_RIGHT] & ~home_mode;
  wire       two_sw    = (base == 4'd2) || (base == 4'd3);
  wire       both_side = (base == 4'd3) || (base == 4'd4);
  wire       target_sw = home_mode ? home_sw :
                         (use_right ? right_sw : left_sw);
  wire       home_pos  = (base == 4'd6) || (base == 4'd7);
  wire       seek_dir  = home_mode ? home_pos : use_right;

  ahd_step_if st ();
  ahd_step_gen u_step (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .st        (st)
  );

  wire busy      = state_reg != ahd_pkg::S_IDLE;
  wire fine_ph   = (state_reg == ahd_pkg::S_LEAVE) ||
                   (state_reg == ahd_pkg::S_FINE) ||
                   (state_reg == ahd_pkg::S_OVER) ||
                   (state_reg == ahd_pkg::S_BACK);
  assign st.run   = busy;
  assign st.speed = fine_ph ? fine_reg : coarse_reg;

  // Reversal for modes 5 and 6 on reaching the stop switch ahead.
  wire rev_hit = (base == 4'd5 && !dir_reg && left_sw) ||
                 (base == 4'd6 && dir_reg && right_sw);
  logic zero_now;
  logic dir_next;

  always_comb begin
    state_next = state_reg;
    dir_next   = dir_reg;
    zero_now   = 1'b0;
    case (state_reg)
      ahd_pkg::S_IDLE: begin
        if (cmd_start && base >= 4'd1 && base <= 4'd8) begin
          state_next = two_sw ? ahd_pkg::S_FIRST : ahd_pkg::S_SEEK;
          dir_next   = two_sw ? 1'b1 : seek_dir;
        end
      end
      ahd_pkg::S_FIRST: begin
        if (right_sw) begin
          state_next = ahd_pkg::S_SEEK;
          dir_next   = 1'b0;
        end
      end
      ahd_pkg::S_SEEK: begin
        if (target_sw) begin
          state_next = ahd_pkg::S_LEAVE;
          dir_next   = ~dir_reg;
        end else if (rev_hit) begin
          dir_next = ~dir_reg;
        end
      end
      ahd_pkg::S_LEAVE: begin
        if (!target_sw) begin
          state_next = ahd_pkg::S_FINE;
          dir_next   = ~dir_reg;
        end
      end
      ahd_pkg::S_FINE: begin
        if (target_sw) begin
          if (both_side) begin
            state_next = ahd_pkg::S_OVER;
          end else begin
            state_next = ahd_pkg::S_IDLE;
            zero_now   = 1'b1;
          end
        end
      end
      ahd_pkg::S_OVER: begin
        if (!target_sw) begin
          state_next = ahd_pkg::S_BACK;
          dir_next   = ~dir_reg;
        end
      end
      ahd_pkg::S_BACK: begin
        if (target_sw) begin
          state_next = ahd_pkg::S_IDLE;
          zero_now   = 1'b1;
        end
      end
      default: begin
        state_next = ahd_pkg::S_IDLE;
      end
    endcase
    if (cmd_stop) begin
      state_next = ahd_pkg::S_IDLE;
    end
  end

  wire [31:0] pos_step = dir_reg ? pos_reg + 32'h0000_0001 :
                                   pos_reg - 32'h0000_0001;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg     <= ahd_pkg::S_IDLE;
      dir_reg       <= 1'b0;
      pos_reg       <= 32'h0000_0000;
      first_pos_reg <= 32'h0000_0000;
      span_reg      <= 32'h0000_0000;
      prezero_reg   <= 32'h0000_0000;
      done_reg      <= 1'b0;
      step_reg      <= 1'b0;
    end else begin
      state_reg <= state_next;
      dir_reg   <= dir_next;
      step_reg  <= st.step & busy;
      if (zero_now) begin
        prezero_reg <= pos_reg;
        pos_reg     <= 32'h0000_0000;
        if (two_sw) begin
          span_reg <= first_pos_reg - pos_reg;
        end
      end else if (st.step && busy) begin
        pos_reg <= pos_step;
      end
      if (state_reg == ahd_pkg::S_FIRST && right_sw) begin
        first_pos_reg <= pos_reg;
      end
      if (zero_now) begin
        done_reg <= 1'b1;
      end else if (motion_cmd) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Error flags: a new event wins over a clear in the same cycle.
  wire [1:0] fault_clr  = {2{rd_fault | motion_cmd}};
  wire [1:0] fault_next = (fault_reg & ~fault_clr) | evt_rise;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fault_reg    <= 2'b00;
      evt_prev_reg <= 2'b00;
    end else begin
      fault_reg    <= fault_next;
      evt_prev_reg <= evt_lvl;
    end
  end

  // Writable parameter registers.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pwm_freq_reg   <= 2'b00;
      autoscale_reg  <= 1'b0;
      mode_reg       <= ahd_pkg::MODE_RST;
      coarse_reg     <= ahd_pkg::COARSE_RST;
      fine_reg       <= ahd_pkg::FINE_RST;
      boost_reg      <= 8'h00;
      fullsteps_reg  <= ahd_pkg::FULLSTEPS_RST;
      standstill_reg <= 2'b00;
      run_cur_reg    <= ahd_pkg::RUN_CUR_RST;
      stby_cur_reg   <= ahd_pkg::STBY_CUR_RST;
    end else if (wr_en) begin
      case (idx)
        ahd_pkg::IDX_PWM_FREQ:   pwm_freq_reg   <= i_avs_writedata[1:0];
        ahd_pkg::IDX_AUTOSCALE:  autoscale_reg  <= i_avs_writedata[0];
        ahd_pkg::IDX_MODE:       mode_reg       <= i_avs_writedata[7:0];
        ahd_pkg::IDX_COARSE:     coarse_reg     <= i_avs_writedata[23:0];
        ahd_pkg::IDX_FINE:       fine_reg       <= i_avs_writedata[23:0];
        ahd_pkg::IDX_BOOST:      boost_reg      <= i_avs_writedata[7:0];
        ahd_pkg::IDX_FULLSTEPS:  fullsteps_reg  <= i_avs_writedata[15:0];
        ahd_pkg::IDX_STANDSTILL: standstill_reg <= i_avs_writedata[1:0];
        ahd_pkg::IDX_CONTROL: begin
          run_cur_reg  <= i_avs_writedata[ahd_pkg::CTL_RUN_LO +: 8];
          stby_cur_reg <= i_avs_writedata[ahd_pkg::CTL_STB_LO +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; unmapped or misaligned addresses read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        ahd_pkg::IDX_PWM_FREQ:   rd_mux = {30'h0, pwm_freq_reg};
        ahd_pkg::IDX_AUTOSCALE:  rd_mux = {31'h0, autoscale_reg};
        ahd_pkg::IDX_MODE:       rd_mux = {24'h0, mode_reg};
        ahd_pkg::IDX_COARSE:     rd_mux = {8'h00, coarse_reg};
        ahd_pkg::IDX_FINE:       rd_mux = {8'h00, fine_reg};
        ahd_pkg::IDX_SPAN:       rd_mux = span_reg;
        ahd_pkg::IDX_PREZERO:    rd_mux = prezero_reg;
        ahd_pkg::IDX_BOOST:      rd_mux = {24'h0, boost_reg};
        ahd_pkg::IDX_FULLSTEPS:  rd_mux = {16'h0, fullsteps_reg};
        ahd_pkg::IDX_STANDSTILL: rd_mux = {30'h0, standstill_reg};
        ahd_pkg::IDX_LOAD:       rd_mux = {22'h0, load_now};
        ahd_pkg::IDX_FAULTS:     rd_mux = {30'h0, fault_reg};
        ahd_pkg::IDX_CONTROL:    rd_mux = {8'h00, stby_cur_reg,
                                           run_cur_reg, 8'h00};
        ahd_pkg::IDX_STATUS:     rd_mux = {29'h0, dir_reg, done_reg, busy};
        ahd_pkg::IDX_POSITION:   rd_mux = pos_reg;
        default:                 rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // One wait cycle per access: waitrequest drops the cycle after a request.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (i_avs_read && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Chopper carrier period from the frequency selector.
  wire [13:0] pwm_period = (pwm_freq_reg == 2'd0) ? ahd_pkg::PWM_P0 :
                           (pwm_freq_reg == 2'd1) ? ahd_pkg::PWM_P1 :
                           (pwm_freq_reg == 2'd2) ? ahd_pkg::PWM_P2 :
                                                    ahd_pkg::PWM_P3;
  wire        pwm_wrap   = pwm_cnt_reg >= pwm_period - 14'd1;

  // Coil current and standstill treatment.
  wire [7:0] ramp_cur  = (boost_reg == 8'h00) ? run_cur_reg :
                                                 boost_reg;
  wire       standing  = ~busy & ~i_ramp_active;
  wire [7:0] cur_sel   = i_ramp_active ? ramp_cur :
                         (standing ? stby_cur_reg : run_cur_reg);
  wire [1:0] cmode_sel = (standing && stby_cur_reg == 8'h00) ?
                         standstill_reg : 2'b00;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pwm_cnt_reg   <= 14'h0000;
      pwm_sync_reg  <= 1'b0;
      auto_out_reg  <= 1'b0;
      cur_out_reg   <= 8'h00;
      cmode_out_reg <= 2'b00;
    end else begin
      pwm_cnt_reg   <= pwm_wrap ? 14'h0000 : pwm_cnt_reg + 14'd1;
      pwm_sync_reg  <= pwm_wrap;
      auto_out_reg  <= autoscale_reg;
      cur_out_reg   <= cur_sel;
      cmode_out_reg <= cmode_sel;
    end
  end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_step            = step_reg;
  assign o_dir             = dir_reg;
  assign o_pwm_sync        = pwm_sync_reg;
  assign o_pwm_autoscale   = auto_out_reg;
  assign o_coil_current    = cur_out_reg;
  assign o_coil_mode       = cmode_out_reg;
endmodule : ahd_axis

/* File: tb/ahd_axis_props.sv */
// Port checker for the axis homing and drive block.
`timescale 1ns/1ps
module ahd_axis_props (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic [9:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_step,
  input wire logic        o_pwm_sync,
  input wire logic        o_pwm_autoscale,
  input wire logic [7:0]  o_coil_current,
  input wire logic [1:0]  o_coil_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = i_avs_read && !o_avs_waitrequest;
  assign wr_ok = i_avs_write && !o_avs_waitrequest;
  AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Wait state longer than one cycle.");
  AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=>
    o_avs_waitrequest) else $error("Wait request low too long.");
  AST_AUTOSCALE: assert property (wr_ok && i_avs_address == 10'h300
    |-> ##2 o_pwm_autoscale == $past(i_avs_writedata[0], 2))
    else $error("Autoscale output does not follow the register.");
  AST_STEP_PULSE: assert property (o_step |=> !o_step)
    else $error("Step pulse longer than one cycle.");
  AST_SYNC_PULSE: assert property (o_pwm_sync |=> !o_pwm_sync [*8])
    else $error("Chopper sync pulses too close.");
  AST_COIL_MODE: assert property (o_coil_mode != 2'b00
    |-> o_coil_current == 8'h00)
    else $error("Standstill option active with nonzero current.");
  AST_LOAD_WIDTH: assert property (rd_ok && i_avs_address == 10'h338
    |-> o_avs_readdata[31:10] == 22'h00_0000)
    else $error("Load reading wider than ten bits.");
  AST_FAULT_WIDTH: assert property (rd_ok && i_avs_address == 10'h33C
    |-> o_avs_readdata[31:2] == 30'h0000_0000)
    else $error("Fault flags wider than two bits.");
  AST_UNMAPPED: assert property (rd_ok && i_avs_address == 10'h3FC
    |-> o_avs_readdata == 32'h0000_0000)
    else $error("Unmapped address reads nonzero.");
  CVR_STEP: cover property (o_step);
  CVR_SHORT: cover property (o_coil_mode == 2'd3);
  CVR_FAULT: cover property (rd_ok && i_avs_address == 10'h33C &&
    o_avs_readdata != 32'h0000_0000);
endmodule : ahd_axis_props

bind ahd_axis ahd_axis_props ahd_axis_props_i (.*);

/* File: tb/ahd_motor_model.sv */
// Motor stage model with end switches, home switch and load sensor.
`timescale 1ns/1ps
module ahd_motor_model #(
  parameter int LEFT_POS  = -20,
  parameter int RIGHT_POS = 30,
  parameter int HOME_LO   = 5,
  parameter int HOME_HI   = 7,
  parameter int SW_W      = 4
) (
  input  wire logic i_clk_sys,
  input  wire logic i_step,
  input  wire logic i_dir,
  output logic      o_left_sw,
  output logic      o_right_sw,
  output logic      o_home_sw,
  output logic [9:0] o_load
);
  int pos = 0;
  always @(posedge i_clk_sys) begin
    if (i_step === 1'b1) begin
      pos <= (i_dir === 1'b1) ? pos + 1 : pos - 1;
    end
  end
  // Stop switches are cams of finite width, so a search can pass through.
  assign o_left_sw  = (pos <= LEFT_POS) && (pos > LEFT_POS - SW_W);
  assign o_right_sw = (pos >= RIGHT_POS) && (pos < RIGHT_POS + SW_W);
  assign o_home_sw  = (pos >= HOME_LO) && (pos <= HOME_HI);
  assign o_load     = 10'(pos * 37 + 300);
endmodule : ahd_motor_model

/* File: tb/ahd_axis_test.sv */
// Self-checking bench for the axis homing and drive block.
`timescale 1ns/1ps
module ahd_axis_test;
  logic        i_clk_sys       = 1'b0;
  logic        i_rst           = 1'b1;
  logic [9:0]  i_avs_address   = 10'h000;
  logic        i_avs_read      = 1'b0;
  logic        i_avs_write     = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [1:0]  evt             = 2'b00;
  logic        i_ramp_active   = 1'b0;
  logic        i_left_sw;
  logic        i_right_sw;
  logic        i_home_sw;
  logic [9:0]  i_load_value;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        o_step;
  logic        o_dir;
  logic        o_pwm_sync;
  logic        o_pwm_autoscale;
  logic [7:0]  o_coil_current;
  logic [1:0]  o_coil_mode;
  logic [31:0] rd;
  int          g;
  int          err_count = 0;
  int          checked   = 0;
  logic [7:0]  ridx [8] = '{ahd_pkg::IDX_PWM_FREQ, ahd_pkg::IDX_AUTOSCALE,
    ahd_pkg::IDX_MODE, ahd_pkg::IDX_COARSE, ahd_pkg::IDX_FINE,
    ahd_pkg::IDX_BOOST, ahd_pkg::IDX_FULLSTEPS, ahd_pkg::IDX_STANDSTILL};
  logic [31:0] rval [8] = '{32'h0, 32'h0, 32'h1, 32'h1000, 32'h100, 32'h0,
    32'hC8, 32'h0};
  int          per  [4] = '{12800, 8537, 6400, 5125};

  always #2.5 i_clk_sys = ~i_clk_sys;

  ahd_axis ahd_axis_i (.*, .i_stall_evt(evt[0]), .i_deviation_evt(evt[1]));
  ahd_motor_model ahd_motor_model_i (.i_clk_sys(i_clk_sys), .i_step(o_step),
    .i_dir(o_dir), .o_left_sw(i_left_sw), .o_right_sw(i_right_sw),
    .o_home_sw(i_home_sw), .o_load(i_load_value));

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_read      <= !wr;
    i_avs_write     <= wr;
    i_avs_address   <= {idx, 2'b00};
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 64);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask : bus

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_sync;
    g = 0;
    do begin
      @(posedge i_clk_sys);
      g++;
    end while (o_pwm_sync !== 1'b1 && g < 20000);
    if (g >= 20000) begin
      err_count++;
      test_done();
    end
  endtask : wait_sync

  task automatic home(input logic [7:0] mode, input logic [31:0] pre);
    int n;
    n = 0;
    bus(1'b1, ahd_pkg::IDX_MODE, {24'h00_0000, mode});
    bus(1'b1, ahd_pkg::IDX_CONTROL, 32'h0040_8001);
    do begin
      bus(1'b0, ahd_pkg::IDX_STATUS, 32'h0000_0000);
      n++;
    end while (rd[1] !== 1'b1 && n < 20000);
    if (rd[1] !== 1'b1) begin
      err_count++;
      test_done();
    end
    chk({31'h0, rd[0]}, 32'h0000_0000);
    rdchk(ahd_pkg::IDX_PREZERO, pre);
    rdchk(ahd_pkg::IDX_POSITION, 32'h0000_0000);
  endtask : home

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rdchk(ridx[k], rval[k]);
    end
    bus(1'b1, 8'hFF, 32'hFFFF_FFFF);
    rdchk(8'hFF, 32'h0000_0000);
    bus(1'b1, ahd_pkg::IDX_FULLSTEPS, 32'h0000_FFFF);
    rdchk(ahd_pkg::IDX_FULLSTEPS, 32'h0000_FFFF);
    bus(1'b1, ahd_pkg::IDX_COARSE, 32'h00FF_FFFF);
    rdchk(ahd_pkg::IDX_COARSE, 32'h00FF_FFFF);
    bus(1'b1, ahd_pkg::IDX_FINE, 32'h0010_0000);
    bus(1'b1, ahd_pkg::IDX_AUTOSCALE, 32'h0000_0001);
    repeat (2) @(posedge i_clk_sys);
    chk(32'(o_pwm_autoscale), 32'h0000_0001);
    rdchk(ahd_pkg::IDX_LOAD, 32'h0000_012C);
    evt <= 2'b11;
    repeat (2) @(posedge i_clk_sys);
    evt <= 2'b00;
    repeat (4) @(posedge i_clk_sys);
    rdchk(ahd_pkg::IDX_FAULTS, 32'h0000_0003);
    rdchk(ahd_pkg::IDX_FAULTS, 32'h0000_0000);
    evt <= 2'b10;
    repeat (2) @(posedge i_clk_sys);
    evt <= 2'b00;
    repeat (4) @(posedge i_clk_sys);
    home(8'h01, 32'hFFFF_FFEC);
    rdchk(ahd_pkg::IDX_FAULTS, 32'h0000_0000);
    home(8'h02, 32'h0000_0000);
    bus(1'b1, ahd_pkg::IDX_SPAN, 32'h1234_5678);
    rdchk(ahd_pkg::IDX_SPAN, 32'h0000_0032);
    home(8'h41, 32'h0000_0032);
    home(8'h08, 32'hFFFF_FFE9);
    home(8'h88, 32'hFFFF_FFFD);
    home(8'h05, 32'h0000_0001);
    home(8'h04, 32'hFFFF_FFE4);
    home(8'h03, 32'h0000_0000);
    rdchk(ahd_pkg::IDX_SPAN, 32'h0000_0035);
    bus(1'b1, ahd_pkg::IDX_CONTROL, 32'h0000_8000);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ahd_pkg::IDX_STANDSTILL, 32'(k));
      repeat (3) @(posedge i_clk_sys);
      chk(32'(o_coil_mode), 32'(k));
      chk(32'(o_coil_current), 32'h0000_0000);
    end
    i_ramp_active <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_coil_current), 32'h0000_0080);
    chk(32'(o_coil_mode), 32'h0000_0000);
    bus(1'b1, ahd_pkg::IDX_BOOST, 32'h0000_0033);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_coil_current), 32'h0000_0033);
    i_ramp_active <= 1'b0;
    bus(1'b1, ahd_pkg::IDX_CONTROL, 32'h0040_8000);
    repeat (3) @(posedge i_clk_sys);
    chk(32'(o_coil_current), 32'h0000_0040);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ahd_pkg::IDX_PWM_FREQ, 32'(k));
      wait_sync();
      wait_sync();
      chk(32'(g), 32'(per[k]));
    end
    test_done();
  end
endmodule : ahd_axis_test
